// *** design/dam_top.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// R1: Each channel samples on the rising edge of its own sample clock.
// R2: Route select high puts channel A on bus A and channel B on bus B.
// R3: Route select low swaps the buses, A onto bus B and B onto bus A.
// R4: Sharing one bus needs route select and both sample clocks tied together outside.
// R5: Power-down low and enable low: channel converts and drives its bus.
// R6: Power-down low and enable high: channel converts, outputs released.
// R7: Power-down high and enable low: nap, outputs released.
// R8: Power-down high and enable high: sleep, outputs released.
// R9: One format selector governs both channels together.
// R10: Four levels pick binary or two's complement and stabilizer on or off.
// R11: Range flag goes high when the input over- or underflows.
// R12: Each result is a 12-bit word with bit 11 as most significant.
// R13: A sample appears on the outputs six sample-clock edges later.
// R14: Two's complement equals straight binary with the top bit inverted.
// R15: An out-of-range sample saturates at the nearest full-scale code.
module dam_top (
    input  wire logic                              sys_clk_in,
    input  wire logic                              rst_in,
    input  wire logic                              chan_a_sample_clock_in,
    input  wire logic                              chan_b_sample_clock_in,
    input  wire logic signed [dam_pkg::LEVEL_W-1:0] chan_a_level_in,
    input  wire logic signed [dam_pkg::LEVEL_W-1:0] chan_b_level_in,
    input  wire logic                              bus_route_select_in,
    input  wire logic                              chan_a_power_down_sel_in,
    input  wire logic                              chan_b_power_down_sel_in,
    input  wire logic                              chan_a_output_enable_n_in,
    input  wire logic                              chan_b_output_enable_n_in,
    input  wire logic [1:0]                        format_level_in,
    input  wire logic [dam_pkg::REG_ADDR_W-1:0]    reg_addr_in,
    input  wire logic [dam_pkg::REG_DATA_W-1:0]    reg_wdata_in,
    input  wire logic                              reg_write_in,
    input  wire logic                              reg_read_in,
    output logic      [dam_pkg::REG_DATA_W-1:0]    reg_rdata_out,
    output logic                                   irq_out,
    output logic      [dam_pkg::DATA_W-1:0]        bus_a_data_out,
    output logic                                   bus_a_data_oe_out,
    output logic                                   chan_a_range_flag_out,
    output logic                                   chan_a_range_flag_oe_out,
    output logic      [dam_pkg::DATA_W-1:0]        bus_b_data_out,
    output logic                                   bus_b_data_oe_out,
    output logic                                   chan_b_range_flag_out,
    output logic                                   chan_b_range_flag_oe_out,
    output logic                                   duty_stab_on_out,
    output logic                                   twos_comp_out,
    output logic      [1:0]                        chan_a_pwr_state_out,
    output logic      [1:0]                        chan_b_pwr_state_out
);
    import dam_pkg::*;

    // ------------------------------------------------------------------
    // Sample clock edge detection.
    // ------------------------------------------------------------------

    // The sample clocks are taken as synchronous levels, so one history
    // flop per channel is enough to find the rising edge.
    logic clk_a_prev_ff;
    logic clk_b_prev_ff;

    wire  edge_a = chan_a_sample_clock_in && !clk_a_prev_ff; // R1
    wire  edge_b = chan_b_sample_clock_in && !clk_b_prev_ff; // R1

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_a_prev_ff <= 1'b0;
            clk_b_prev_ff <= 1'b0;
        end else begin
            clk_a_prev_ff <= chan_a_sample_clock_in;
            clk_b_prev_ff <= chan_b_sample_clock_in;
        end
    end

    // ------------------------------------------------------------------
    // Power and output-enable modes, one decoder per channel.
    // ------------------------------------------------------------------

    dam_pwr_t pwr_a;
    dam_pwr_t pwr_b;
    logic     conv_a;
    logic     conv_b;
    logic     drive_a;
    logic     drive_b;

    dam_pwr_decode u_pwr_a (
        .power_down_sel_in  (chan_a_power_down_sel_in),
        .output_enable_n_in (chan_a_output_enable_n_in),
        .pwr_state_out      (pwr_a),
        .converting_out     (conv_a),
        .driving_out        (drive_a)
    );

    dam_pwr_decode u_pwr_b (
        .power_down_sel_in  (chan_b_power_down_sel_in),
        .output_enable_n_in (chan_b_output_enable_n_in),
        .pwr_state_out      (pwr_b),
        .converting_out     (conv_b),
        .driving_out        (drive_b)
    );

    // ------------------------------------------------------------------
    // Conversion pipelines.
    // ------------------------------------------------------------------

    // A napping or sleeping channel freezes its pipeline; the words it
    // holds are stale when it wakes and are flushed by seven new edges.
    logic [DATA_W-1:0] code_a;
    logic [DATA_W-1:0] code_b;
    logic              flag_a;
    logic              flag_b;

    dam_chan_pipe u_pipe_a (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .sample_edge_in (edge_a),
        .run_in         (conv_a),
        .level_in       (chan_a_level_in),
        .code_out       (code_a),
        .range_flag_out (flag_a)
    );

    dam_chan_pipe u_pipe_b (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .sample_edge_in (edge_b),
        .run_in         (conv_b),
        .level_in       (chan_b_level_in),
        .code_out       (code_b),
        .range_flag_out (flag_b)
    );

    // ------------------------------------------------------------------
    // Format and stabilizer selector, shared by both channels.
    // ------------------------------------------------------------------

    dam_fmt_level_t fmt_level;
    assign fmt_level = dam_fmt_level_t'(format_level_in); // R9

    wire twos_sel = (fmt_level == LVL_TWO_THIRDS) || (fmt_level == LVL_SUPPLY); // R10
    wire stab_sel = (fmt_level == LVL_ONE_THIRD) || (fmt_level == LVL_TWO_THIRDS); // R10

    // Inverting the top bit moves mid-scale to zero.
    wire [DATA_W-1:0] msb_flip = twos_sel ? (CODE_ZERO | (12'h001 << MSB_POS)) : CODE_ZERO;
    wire [DATA_W-1:0] word_a   = code_a ^ msb_flip; // R14 R12
    wire [DATA_W-1:0] word_b   = code_b ^ msb_flip; // R14 R12

    // ------------------------------------------------------------------
    // Bus routing.
    // ------------------------------------------------------------------

    // The enable of the channel whose word sits on a bus drives that bus,
    // so a swap carries each channel's enable with its data. Tying the
    // route select to both sample clocks interleaves the two channels.
    wire [DATA_W-1:0] nxt_bus_a_data = bus_route_select_in ? word_a : word_b; // R2 R3 R4
    wire [DATA_W-1:0] nxt_bus_b_data = bus_route_select_in ? word_b : word_a; // R2 R3
    wire              nxt_bus_a_flag = bus_route_select_in ? flag_a : flag_b; // R2 R3
    wire              nxt_bus_b_flag = bus_route_select_in ? flag_b : flag_a; // R2 R3
    wire              nxt_bus_a_oe   = bus_route_select_in ? drive_a : drive_b; // R5 R6 R7 R8
    wire              nxt_bus_b_oe   = bus_route_select_in ? drive_b : drive_a; // R5 R6 R7 R8

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_a_data_out           <= CODE_ZERO;
            bus_b_data_out           <= CODE_ZERO;
            chan_a_range_flag_out    <= 1'b0;
            chan_b_range_flag_out    <= 1'b0;
            bus_a_data_oe_out        <= 1'b0;
            bus_b_data_oe_out        <= 1'b0;
            chan_a_range_flag_oe_out <= 1'b0;
            chan_b_range_flag_oe_out <= 1'b0;
        end else begin
            bus_a_data_out           <= nxt_bus_a_data;
            bus_b_data_out           <= nxt_bus_b_data;
            chan_a_range_flag_out    <= nxt_bus_a_flag;
            chan_b_range_flag_out    <= nxt_bus_b_flag;
            bus_a_data_oe_out        <= nxt_bus_a_oe;
            bus_b_data_oe_out        <= nxt_bus_b_oe;
            chan_a_range_flag_oe_out <= nxt_bus_a_oe;
            chan_b_range_flag_oe_out <= nxt_bus_b_oe;
        end
    end

    // ------------------------------------------------------------------
    // Mode status outputs.
    // ------------------------------------------------------------------

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            duty_stab_on_out     <= 1'b0;
            twos_comp_out        <= 1'b0;
            chan_a_pwr_state_out <= 2'h0;
            chan_b_pwr_state_out <= 2'h0;
        end else begin
            duty_stab_on_out     <= stab_sel; // R10
            twos_comp_out        <= twos_sel; // R10
            chan_a_pwr_state_out <= pwr_a;
            chan_b_pwr_state_out <= pwr_b;
        end
    end

    // ------------------------------------------------------------------
    // Range events and interrupt.
    // ------------------------------------------------------------------

    // An event is the rising edge of a channel's pipeline flag, so a long
    // overload raises one interrupt rather than one per sample.
    logic flag_a_prev_ff;
    logic flag_b_prev_ff;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_a_prev_ff <= 1'b0;
            flag_b_prev_ff <= 1'b0;
        end else begin
            flag_a_prev_ff <= flag_a;
            flag_b_prev_ff <= flag_b;
        end
    end

    logic [EVT_W-1:0] status_ff;
    logic [EVT_W-1:0] mask_ff;
    logic [EVT_W-1:0] evt;

    assign evt[EVT_RANGE_A] = flag_a && !flag_a_prev_ff; // R11
    assign evt[EVT_RANGE_B] = flag_b && !flag_b_prev_ff; // R11

    // ------------------------------------------------------------------
    // Register port.
    // ------------------------------------------------------------------

    wire hit_status = reg_addr_in == ADDR_STATUS;
    wire hit_mask   = reg_addr_in == ADDR_MASK;
    wire hit_state  = reg_addr_in == ADDR_STATE;

    wire [EVT_W-1:0] status_clr = (reg_write_in && hit_status) ? reg_wdata_in[EVT_W-1:0] : EVT_RESET;

    // A new event in the same cycle as its clear keeps the bit set.
    wire [EVT_W-1:0] nxt_status = (status_ff & ~status_clr) | evt;
    wire [EVT_W-1:0] nxt_mask   = (reg_write_in && hit_mask) ? reg_wdata_in[EVT_W-1:0] : mask_ff;

    logic [REG_DATA_W-1:0] state_word;
    always_comb begin
        state_word = RD_ZERO;
        state_word[STATE_PWR_A_LSB +: 2] = pwr_a;
        state_word[STATE_PWR_B_LSB +: 2] = pwr_b;
        state_word[STATE_TWOS_BIT]       = twos_sel;
        state_word[STATE_STAB_BIT]       = stab_sel;
        state_word[STATE_ROUTE_BIT]      = bus_route_select_in;
    end

    wire [REG_DATA_W-1:0] rd_mux = hit_status ? {{(REG_DATA_W-EVT_W){1'b0}}, status_ff}
                                 : hit_mask   ? {{(REG_DATA_W-EVT_W){1'b0}}, mask_ff}
                                 : hit_state  ? state_word
                                 : RD_ZERO;

    wire [REG_DATA_W-1:0] nxt_rdata = reg_read_in ? rd_mux : RD_ZERO;
    wire                  nxt_irq   = |(nxt_status & nxt_mask);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_ff     <= EVT_RESET;
            mask_ff       <= EVT_RESET;
            reg_rdata_out <= RD_ZERO;
            irq_out       <= 1'b0;
        end else begin
            status_ff     <= nxt_status;
            mask_ff       <= nxt_mask;
            reg_rdata_out <= nxt_rdata;
            irq_out       <= nxt_irq;
        end
    end

endmodule // dam_top

// *** design/dam_pkg.sv ***
package dam_pkg;

    localparam int DATA_W       = 12;
    localparam int LEVEL_W      = 14;
    localparam int PIPE_LATENCY = 6;
    localparam int MSB_POS      = 11;

    localparam logic [DATA_W-1:0]  CODE_FULL  = 12'hFFF;
    localparam logic [DATA_W-1:0]  CODE_ZERO  = 12'h000;
    localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 14'h0000;
    localparam logic [LEVEL_W-1:0] LEVEL_FULL = 14'h0FFF;

    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 32;

    localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [REG_ADDR_W-1:0] ADDR_MASK   = 4'h4;
    localparam logic [REG_ADDR_W-1:0] ADDR_STATE  = 4'h8;

    localparam int EVT_W         = 2;
    localparam int EVT_RANGE_A   = 0;
    localparam int EVT_RANGE_B   = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    localparam int STATE_PWR_A_LSB = 0;
    localparam int STATE_PWR_B_LSB = 2;
    localparam int STATE_TWOS_BIT  = 4;
    localparam int STATE_STAB_BIT  = 5;
    localparam int STATE_ROUTE_BIT = 6;

    localparam logic [REG_DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_HIZ,
        PWR_NAP,
        PWR_SLEEP
    } dam_pwr_t;

    typedef enum logic [1:0] {
        LVL_GROUND,
        LVL_ONE_THIRD,
        LVL_TWO_THIRDS,
        LVL_SUPPLY
    } dam_fmt_level_t;

endpackage

// *** design/dam_pwr_decode.sv ***
`timescale 1ns/1ns
module dam_pwr_decode (
    input  wire logic          power_down_sel_in,
    input  wire logic          output_enable_n_in,
    output dam_pkg::dam_pwr_t  pwr_state_out,
    output logic               converting_out,
    output logic               driving_out
);
    import dam_pkg::*;

    // The two pins form a four-way mode; only the fully awake, enabled pair drives the bus.
    assign pwr_state_out  = power_down_sel_in
                          ? (output_enable_n_in ? PWR_SLEEP : PWR_NAP)   // R7 R8
                          : (output_enable_n_in ? PWR_HIZ   : PWR_NORMAL); // R5 R6
    assign converting_out = !power_down_sel_in; // R5 R6 R7 R8
    assign driving_out    = !power_down_sel_in && !output_enable_n_in; // R5 R6 R7 R8

endmodule // dam_pwr_decode

// *** design/dam_chan_pipe.sv ***
`timescale 1ns/1ns
module dam_chan_pipe (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        sample_edge_in,
    input  wire logic                        run_in,
    input  wire logic signed [dam_pkg::LEVEL_W-1:0] level_in,
    output logic             [dam_pkg::DATA_W-1:0]  code_out,
    output logic                             range_flag_out
);
    import dam_pkg::*;

    logic [DATA_W-1:0] code_ff [PIPE_LATENCY+1];
    logic              flag_ff [PIPE_LATENCY+1];
    logic [DATA_W-1:0] nxt_code;
    logic              nxt_flag;
    wire               step = sample_edge_in && run_in;
    wire               under = level_in < $signed(LEVEL_ZERO);
    wire               over  = level_in > $signed(LEVEL_FULL);

    // Out-of-range inputs clamp to the nearest end of the scale and raise the flag.
    assign nxt_flag = under || over; // R11
    assign nxt_code = under ? CODE_ZERO : (over ? CODE_FULL : level_in[DATA_W-1:0]); // R15

    // Entry 0 holds the sample taken on the edge; it reaches the last entry six edges later.
    generate
        for (genvar i = 0; i <= PIPE_LATENCY; i++) begin : g_stage
            always_ff @(posedge sys_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    code_ff[i] <= CODE_ZERO;
                    flag_ff[i] <= 1'b0;
                end else if (step) begin // R1
                    code_ff[i] <= (i == 0) ? nxt_code : code_ff[(i == 0) ? 0 : i-1]; // R13
                    flag_ff[i] <= (i == 0) ? nxt_flag : flag_ff[(i == 0) ? 0 : i-1];
                end
            end
        end
    endgenerate

    assign code_out       = code_ff[PIPE_LATENCY];
    assign range_flag_out = flag_ff[PIPE_LATENCY];

endmodule // dam_chan_pipe

// *** verif/dam_props.sv ***
`timescale 1ns/1ns
module dam_props (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        chan_a_sample_clock_in,
    input wire logic        chan_b_sample_clock_in,
    input wire logic        bus_route_select_in,
    input wire logic        chan_a_power_down_sel_in,
    input wire logic        chan_b_power_down_sel_in,
    input wire logic        chan_a_output_enable_n_in,
    input wire logic        chan_b_output_enable_n_in,
    input wire logic [1:0]  format_level_in,
    input wire logic [11:0] bus_a_data_out,
    input wire logic        bus_a_data_oe_out,
    input wire logic        chan_a_range_flag_out,
    input wire logic [11:0] bus_b_data_out,
    input wire logic        bus_b_data_oe_out,
    input wire logic        chan_b_range_flag_out,
    input wire logic        duty_stab_on_out,
    input wire logic        twos_comp_out,
    input wire logic [1:0]  chan_a_pwr_state_out,
    input wire logic [1:0]  chan_b_pwr_state_out
);
    // Outputs at the first edge after release still hold reset values, so all checks but the saturation ones wait one edge.
    logic arm_ff;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) arm_ff <= 1'b0;
        else arm_ff <= 1'b1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_calm;
        $stable(chan_a_sample_clock_in) && $stable(chan_b_sample_clock_in) && $stable(format_level_in)
        && chan_a_pwr_state_out == 2'h0 && chan_b_pwr_state_out == 2'h0;
    endsequence
    sequence s_swap;
        arm_ff && $changed(bus_route_select_in) ##0 s_calm;
    endsequence
    property p_swap;
        s_swap |=> bus_a_data_out == $past(bus_b_data_out) && chan_a_range_flag_out == $past(chan_b_range_flag_out);
    endproperty
    property p_stab;
        arm_ff |-> duty_stab_on_out == ($past(format_level_in) inside {2'h1, 2'h2});
    endproperty
    property p_twos;
        arm_ff |-> twos_comp_out == $past(format_level_in[1]);
    endproperty
    property p_pwr_a;
        arm_ff |-> chan_a_pwr_state_out == $past({chan_a_power_down_sel_in, chan_a_output_enable_n_in});
    endproperty
    property p_pwr_b;
        arm_ff |-> chan_b_pwr_state_out == $past({chan_b_power_down_sel_in, chan_b_output_enable_n_in});
    endproperty
    property p_oe_a;
        arm_ff |-> bus_a_data_oe_out == (($past(bus_route_select_in) ? chan_a_pwr_state_out : chan_b_pwr_state_out) == 2'h0);
    endproperty
    property p_oe_b;
        arm_ff |-> bus_b_data_oe_out == (($past(bus_route_select_in) ? chan_b_pwr_state_out : chan_a_pwr_state_out) == 2'h0);
    endproperty
    property p_sat_a;
        chan_a_range_flag_out && bus_a_data_oe_out |-> bus_a_data_out[10:0] inside {11'h000, 11'h7FF};
    endproperty
    property p_sat_b;
        chan_b_range_flag_out && bus_b_data_oe_out |-> bus_b_data_out[10:0] inside {11'h000, 11'h7FF};
    endproperty
    a_swap: assert property (p_swap) else $error("bus swap did not exchange words");
    a_stab: assert property (p_stab) else $error("stabilizer decode wrong");
    a_twos: assert property (p_twos) else $error("format decode wrong");
    a_pwr_a: assert property (p_pwr_a) else $error("channel A mode wrong");
    a_pwr_b: assert property (p_pwr_b) else $error("channel B mode wrong");
    a_oe_a: assert property (p_oe_a) else $error("bus A enable wrong");
    a_oe_b: assert property (p_oe_b) else $error("bus B enable wrong");
    a_sat_a: assert property (p_sat_a) else $error("bus A not saturated");
    a_sat_b: assert property (p_sat_b) else $error("bus B not saturated");
endmodule // dam_props
bind dam_top dam_props dam_props_i (.sys_clk_in, .rst_in, .chan_a_sample_clock_in, .chan_b_sample_clock_in,
    .bus_route_select_in, .chan_a_power_down_sel_in, .chan_b_power_down_sel_in, .chan_a_output_enable_n_in,
    .chan_b_output_enable_n_in, .format_level_in, .bus_a_data_out, .bus_a_data_oe_out, .chan_a_range_flag_out,
    .bus_b_data_out, .bus_b_data_oe_out, .chan_b_range_flag_out, .duty_stab_on_out, .twos_comp_out,
    .chan_a_pwr_state_out, .chan_b_pwr_state_out);

// *** verif/dam_capture_model.sv ***
`timescale 1ns/1ns
module dam_capture_model (
    input  wire logic             sys_clk_in,
    input  wire logic [1:0][11:0] data_in,
    input  wire logic [1:0]       oe_in,
    input  wire logic [1:0]       flag_in,
    input  wire logic [1:0]       flag_oe_in,
    output logic      [1:0][11:0] word_out,
    output logic      [1:0]       flag_out
);
    // A released bus flips every cycle, so it shows the inverse of the last driven word and that word itself on alternate cycles.
    logic [1:0][11:0] float_ff;
    logic [1:0]       flag_float_ff;
    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < 2; i++) begin
            float_ff[i] <= oe_in[i] ? ~data_in[i] : ~float_ff[i];
            flag_float_ff[i] <= flag_oe_in[i] ? ~flag_in[i] : ~flag_float_ff[i];
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            word_out[i] = oe_in[i] ? data_in[i] : float_ff[i];
            flag_out[i] = flag_oe_in[i] ? flag_in[i] : flag_float_ff[i];
        end
    end
endmodule // dam_capture_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import dam_pkg::*;
    typedef struct {logic route; logic [1:0] fmt; logic [13:0] la, lb; logic [11:0] ea, eb; logic fa, fb;} dam_row_t;
    logic        sys_clk_in, rst_in, chan_a_sample_clock_in, chan_b_sample_clock_in, bus_route_select_in;
    logic        chan_a_power_down_sel_in, chan_b_power_down_sel_in, chan_a_output_enable_n_in;
    logic        chan_b_output_enable_n_in, reg_write_in, reg_read_in, irq_out, bus_a_data_oe_out;
    logic        chan_a_range_flag_out, chan_a_range_flag_oe_out, bus_b_data_oe_out, chan_b_range_flag_out;
    logic        chan_b_range_flag_oe_out, duty_stab_on_out, twos_comp_out;
    logic signed [LEVEL_W-1:0] chan_a_level_in, chan_b_level_in;
    logic [1:0]  format_level_in, chan_a_pwr_state_out, chan_b_pwr_state_out, seen_flag;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [11:0] bus_a_data_out, bus_b_data_out;
    logic [1:0][11:0] seen;
    int          mismatches, cmp_count;
    dam_row_t rows [4] = '{
        '{1'b1, 2'h0, 14'h0064, 14'h0FFF, 12'h064, 12'hFFF, 1'b0, 1'b0},
        '{1'b0, 2'h1, 14'h0064, 14'h0FFF, 12'hFFF, 12'h064, 1'b0, 1'b0},
        '{1'b1, 2'h2, 14'h3FFB, 14'h1388, 12'h800, 12'h7FF, 1'b1, 1'b1},
        '{1'b0, 2'h3, 14'h0000, 14'h0800, 12'h000, 12'h800, 1'b0, 1'b0}};
    dam_top dam_top_i (.sys_clk_in, .rst_in, .chan_a_sample_clock_in, .chan_b_sample_clock_in, .chan_a_level_in,
        .chan_b_level_in, .bus_route_select_in, .chan_a_power_down_sel_in, .chan_b_power_down_sel_in,
        .chan_a_output_enable_n_in, .chan_b_output_enable_n_in, .format_level_in, .reg_addr_in, .reg_wdata_in,
        .reg_write_in, .reg_read_in, .reg_rdata_out, .irq_out, .bus_a_data_out, .bus_a_data_oe_out,
        .chan_a_range_flag_out, .chan_a_range_flag_oe_out, .bus_b_data_out, .bus_b_data_oe_out,
        .chan_b_range_flag_out, .chan_b_range_flag_oe_out, .duty_stab_on_out, .twos_comp_out,
        .chan_a_pwr_state_out, .chan_b_pwr_state_out);
    dam_capture_model dam_capture_model_i (.sys_clk_in, .data_in({bus_b_data_out, bus_a_data_out}),
        .oe_in({bus_b_data_oe_out, bus_a_data_oe_out}), .flag_in({chan_b_range_flag_out, chan_a_range_flag_out}),
        .flag_oe_in({chan_b_range_flag_oe_out, chan_a_range_flag_oe_out}), .word_out(seen), .flag_out(seen_flag));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulse(input int n, input logic [1:0] which);
        repeat (n) begin
            @(posedge sys_clk_in);
            {chan_b_sample_clock_in, chan_a_sample_clock_in} <= which;
            @(posedge sys_clk_in);
            {chan_b_sample_clock_in, chan_a_sample_clock_in} <= 2'h0;
        end
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        @(negedge sys_clk_in);
        d = reg_rdata_out;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        mismatches++;
        give_verdict();
    end
    initial begin
        logic [31:0] v;
        {rst_in, bus_route_select_in} = 2'h3;
        {chan_a_sample_clock_in, chan_b_sample_clock_in, reg_write_in, reg_read_in} = 4'h0;
        {chan_a_power_down_sel_in, chan_b_power_down_sel_in} = 2'h0;
        {chan_a_output_enable_n_in, chan_b_output_enable_n_in, format_level_in} = 4'h0;
        {chan_a_level_in, chan_b_level_in, reg_addr_in, reg_wdata_in} = '0;
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            @(posedge sys_clk_in);
            bus_route_select_in <= rows[i].route;
            format_level_in <= rows[i].fmt;
            chan_a_level_in <= rows[i].la;
            chan_b_level_in <= rows[i].lb;
            pulse(7, 2'h3);
            chk(seen[0], rows[i].ea);
            chk(seen[1], rows[i].eb);
            chk(seen_flag, {rows[i].fb, rows[i].fa});
            chk(twos_comp_out, rows[i].fmt[1]);
            chk(duty_stab_on_out, rows[i].fmt inside {2'h1, 2'h2});
        end
        {bus_route_select_in, format_level_in, chan_a_level_in} <= {3'h4, 14'h0123};
        pulse(6, 2'h3);
        chk(seen[0], 12'h000);
        pulse(1, 2'h3);
        chk(seen[0], 12'h123);
        {chan_a_level_in, chan_b_level_in} <= {14'h0200, 14'h0300};
        pulse(7, 2'h2);
        chk(seen[0], 12'h123);
        chk(seen[1], 12'h300);
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk_in);
            {chan_a_power_down_sel_in, chan_a_output_enable_n_in} <= 2'(k);
            {chan_b_power_down_sel_in, chan_b_output_enable_n_in} <= 2'(k);
            repeat (2) @(negedge sys_clk_in);
            chk({chan_a_pwr_state_out, chan_b_pwr_state_out}, {2'(k), 2'(k)});
            chk({bus_a_data_oe_out, chan_a_range_flag_oe_out}, (k % 4 == 0) ? 2'h3 : 2'h0);
            if (k inside {1, 2}) begin
                chan_a_level_in <= (k == 1) ? 14'h0456 : 14'h0789;
                pulse(7, 2'h3);
            end
        end
        {chan_a_level_in, chan_b_level_in} <= {14'h0111, 14'h0222};
        pulse(1, 2'h0);
        chk(seen[0], 12'h456);
        pulse(7, 2'h3);
        repeat (2) begin
            @(posedge sys_clk_in);
            {chan_a_sample_clock_in, chan_b_sample_clock_in, bus_route_select_in} <= 3'h7;
            @(posedge sys_clk_in);
            {chan_a_sample_clock_in, chan_b_sample_clock_in, bus_route_select_in} <= 3'h0;
            @(negedge sys_clk_in);
            chk(seen[0], 12'h111);
            @(negedge sys_clk_in);
            chk(seen[0], 12'h222);
        end
        chk(seen[1], 12'h111);
        bus_route_select_in <= 1'b1;
        wr(ADDR_STATUS, 32'h3);
        wr(ADDR_MASK, 32'h1);
        rd(ADDR_MASK, v);
        chk({v[30:0], irq_out}, 32'h2);
        chan_a_level_in <= 14'h3FFB;
        pulse(7, 2'h1);
        chk({seen[0], seen_flag[0], irq_out}, 14'h3);
        rd(ADDR_STATUS, v);
        chk(v, 32'h1);
        wr(ADDR_MASK, 32'h0);
        @(negedge sys_clk_in);
        chk(irq_out, 1'b0);
        wr(ADDR_STATUS, 32'h1);
        wr(4'hC, 32'hFFFF_FFFF);
        wr(ADDR_STATE, 32'h0);
        rd(4'hC, v);
        chk(v, 32'h0);
        rd(ADDR_STATUS, v);
        chk(v, 32'h0);
        rd(ADDR_STATE, v);
        chk(v, 32'h40);
        wr(ADDR_MASK, 32'h3);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        @(negedge sys_clk_in);
        chk({bus_a_data_oe_out, bus_b_data_oe_out, irq_out, bus_a_data_out}, 15'h0);
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rd(ADDR_MASK, v);
        chk(v, 32'h0);
        give_verdict();
    end
endmodule // tb_top
